//--- logic/awt_defines.svh
// Operation
// - post trigger taken from any pin, edge selectable
// - pretrigger countdown, then reload post-trigger scan count
// - post trigger ignored before pretrigger countdown ends
// - exactly programmed scans after post trigger, then halt
// - post trigger output pulse 25-50 ns
// - scan start edge begins scan, starts sample counter
// - scan start output as pulse or in-progress level
// - conversions blocked until scan start; first timed conversion
// - scan interval counter starts on start trigger, stops
// - scan starts only inside sequence, gated
// - conversion output active-low 50-100 ns pulse
// - sample counter counts per scan, then reloads
// - no conversions outside an acquisition sequence
// - acquisition gate level masks scan starts
// - gate changes act only at scan boundaries
// - scan interval clock from pin or timebases
// - mux strobe 450 ns, 50-100 ns after conversion
// - latch strobe software level or eight-pulse burst
// - waveform trigger starts generation and update counter
// - refresh input needs posted-update mode set
// - refresh output active-low 50-75 ns pulse
// - update counter stoppable; software gate suppresses updates
// - start trigger edge begins acquisition sequence
// - one conversion per scan start
`ifndef AWT_DEFINES_SVH
`define AWT_DEFINES_SVH
`define AWT_CLK_NS 10
`define AWT_CYC_UP(ns) (((ns) + `AWT_CLK_NS - 1) / `AWT_CLK_NS)
`define AWT_CYC_DN(ns) ((ns) / `AWT_CLK_NS)
`define AWT_TRIG_PULSE_NS 25
`define AWT_CONV_PULSE_NS 50
`define AWT_UPD_PULSE_NS 50
`define AWT_MUX_DELAY_NS 50
`define AWT_MUX_WIDTH_NS 450
`define AWT_TB_FAST_NS 50
`define AWT_TB_SLOW_NS 10000
`define AWT_STB_SLOW_NS 10000
`define AWT_STB_FAST_NS 1200
`define AWT_STB_PHASES 16
`define AWT_NUM_PINS 10
`define AWT_PIN_START 0
`define AWT_PIN_POST 1
`define AWT_PIN_CONV 2
`define AWT_PIN_REFRESH 5
`define AWT_PIN_WAVE 6
`define AWT_PIN_SCAN 7
`define AWT_PIN_IDLE 10'h024
`define AWT_SI_FAST 2'h0
`define AWT_SI_SLOW 2'h1
`endif

//--- logic/awt_pkg.sv
package awt_pkg;
  typedef enum logic [1:0] {
    AWT_IDLE = 2'h0,
    AWT_PRE = 2'h1,
    AWT_ARMED = 2'h3,
    AWT_POST = 2'h2
  } awt_acq_t;
endpackage

//--- logic/awt_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "awt_defines.svh"
module awt_engine #(
  parameter int CW = 16
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // function pins
  input wire logic [`AWT_NUM_PINS-1:0] PIN_IN,
  output logic [`AWT_NUM_PINS-1:0] PIN_OUT,
  output logic [`AWT_NUM_PINS-1:0] PIN_OE,
  input wire logic [`AWT_NUM_PINS-1:0] PIN_DRIVE_EN,
  // input routing
  input wire logic [3:0] START_TRIG_SEL,
  input wire logic START_TRIG_POL,
  input wire logic START_TRIG_EXT,
  input wire logic SW_START,
  input wire logic [3:0] POST_TRIG_SEL,
  input wire logic POST_TRIG_POL,
  input wire logic [3:0] SCAN_START_SEL,
  input wire logic SCAN_START_POL,
  input wire logic [3:0] CONVERT_SEL,
  input wire logic CONVERT_POL,
  input wire logic [3:0] GATE_SEL,
  input wire logic GATE_POL,
  input wire logic [3:0] SI_CLK_SEL,
  input wire logic SI_CLK_POL,
  input wire logic [3:0] WF_TRIG_SEL,
  input wire logic WF_TRIG_POL,
  input wire logic [3:0] REFRESH_SEL,
  input wire logic REFRESH_POL,
  // acquisition control
  input wire logic PRETRIG_MODE,
  input wire logic [CW-1:0] PRETRIG_SCANS,
  input wire logic [CW-1:0] POST_SCANS,
  input wire logic SCAN_EXT,
  input wire logic [1:0] SI_SRC,
  input wire logic [CW-1:0] SI_RELOAD,
  input wire logic CONVERT_EXT,
  input wire logic [CW-1:0] SAMPLE_RELOAD,
  input wire logic GATE_EN,
  input wire logic SW_GATE,
  input wire logic SW_STOP,
  input wire logic SCAN_LEVEL_MODE,
  // mux and latch strobes
  input wire logic MUX_EN,
  input wire logic MUX_POL,
  input wire logic STROBE_HW_MODE,
  input wire logic STROBE_SW_LEVEL,
  input wire logic STROBE_GO,
  input wire logic STROBE_SLOW,
  // waveform output control
  input wire logic UPDATE_EXT,
  input wire logic UI_SLOW,
  input wire logic [CW-1:0] UI_RELOAD,
  input wire logic [CW-1:0] BUF_COUNT,
  input wire logic POSTED_UPDATE,
  input wire logic AO_SW_GATE,
  input wire logic AO_SW_STOP,
  // status and converter strobes
  output logic ACQ_ACTIVE,
  output logic SCAN_BUSY,
  output logic ADC_CONVERT,
  output logic WF_ACTIVE,
  output logic DAC_UPDATE,
  output logic MUX_ADVANCE,
  output logic LATCH_STROBE_N
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] pin_s1, pin_s2, pin_s3;
  function automatic logic pick(input logic [15:0] v, input logic [3:0] s, input logic p);
    pick = v[s] ^ p;
  endfunction
  // two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      pin_s1 <= 16'h0;
      pin_s2 <= 16'h0;
      pin_s3 <= 16'h0;
    end else begin
      pin_s1 <= {{(16-`AWT_NUM_PINS){1'b0}}, PIN_IN};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  logic e_start, e_post, e_scan, e_conv, e_si, e_wf, e_ref, gate_lvl;
  assign e_start = pick(pin_s2, START_TRIG_SEL, START_TRIG_POL) &
                   ~pick(pin_s3, START_TRIG_SEL, START_TRIG_POL);
  assign e_post = pick(pin_s2, POST_TRIG_SEL, POST_TRIG_POL) &
                  ~pick(pin_s3, POST_TRIG_SEL, POST_TRIG_POL);
  assign e_scan = pick(pin_s2, SCAN_START_SEL, SCAN_START_POL) &
                  ~pick(pin_s3, SCAN_START_SEL, SCAN_START_POL);
  assign e_conv = pick(pin_s2, CONVERT_SEL, CONVERT_POL) &
                  ~pick(pin_s3, CONVERT_SEL, CONVERT_POL);
  assign e_si = pick(pin_s2, SI_CLK_SEL, SI_CLK_POL) &
                ~pick(pin_s3, SI_CLK_SEL, SI_CLK_POL);
  assign e_wf = pick(pin_s2, WF_TRIG_SEL, WF_TRIG_POL) &
                ~pick(pin_s3, WF_TRIG_SEL, WF_TRIG_POL);
  assign e_ref = pick(pin_s2, REFRESH_SEL, REFRESH_POL) &
                 ~pick(pin_s3, REFRESH_SEL, REFRESH_POL);
  assign gate_lvl = pick(pin_s2, GATE_SEL, GATE_POL);

  ////////////////////////////////////////////////////////////////////////////
  // internal timebases
  logic [9:0] tb_fast, tb_slow;
  logic tick_fast, tick_slow;
  assign tick_fast = tb_fast == 10'(`AWT_CYC_DN(`AWT_TB_FAST_NS) - 1);
  assign tick_slow = tb_slow == 10'(`AWT_CYC_DN(`AWT_TB_SLOW_NS) - 1);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      tb_fast <= 10'h0;
      tb_slow <= 10'h0;
    end else begin
      tb_fast <= tick_fast ? 10'h0 : tb_fast + 10'h1;
      tb_slow <= tick_slow ? 10'h0 : tb_slow + 10'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition sequence
  awt_pkg::awt_acq_t st;
  logic [CW-1:0] scan_cnt, si_cnt, samp_cnt;
  logic last_scan, scan_busy, si_tick, si_req, scan_req, gate_act;
  logic start_go, post_go, scan_go, conv_go;
  assign start_go = (START_TRIG_EXT ? e_start : SW_START) &&
                    st == awt_pkg::AWT_IDLE;
  assign post_go = e_post && st == awt_pkg::AWT_ARMED;
  assign gate_act = (GATE_EN && gate_lvl) || SW_GATE;
  assign scan_req = SCAN_EXT ? e_scan : si_req;
  // gate sampled only when no scan is running, so scans are never cut
  assign scan_go = scan_req && st != awt_pkg::AWT_IDLE && !last_scan &&
                   !scan_busy && !gate_act;
  assign conv_go = scan_busy && st != awt_pkg::AWT_IDLE &&
                   (CONVERT_EXT ? e_conv : samp_cnt == '0);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st <= awt_pkg::AWT_IDLE;
      scan_cnt <= '0;
      last_scan <= 1'b0;
    end else if (SW_STOP) begin
      st <= awt_pkg::AWT_IDLE;
      last_scan <= 1'b0;
    end else begin
      case (st)
        awt_pkg::AWT_IDLE: begin
          last_scan <= 1'b0;
          if (start_go) begin
            st <= PRETRIG_MODE ? awt_pkg::AWT_PRE : awt_pkg::AWT_POST;
            scan_cnt <= PRETRIG_MODE ? PRETRIG_SCANS : POST_SCANS;
          end
        end
        awt_pkg::AWT_PRE: begin
          if (scan_cnt == '0) begin
            st <= awt_pkg::AWT_ARMED;
            scan_cnt <= POST_SCANS;
          end else if (scan_go) begin
            scan_cnt <= scan_cnt - CW'(1);
          end
        end
        awt_pkg::AWT_ARMED: begin
          if (post_go) begin
            st <= awt_pkg::AWT_POST;
          end
        end
        awt_pkg::AWT_POST: begin
          if (last_scan && conv_go) begin
            st <= awt_pkg::AWT_IDLE;
          end else if (scan_go) begin
            scan_cnt <= scan_cnt - CW'(1);
            last_scan <= scan_cnt <= CW'(1);
          end
        end
        default: st <= awt_pkg::AWT_IDLE;
      endcase
    end
  end

  // scan interval counter
  always_comb begin
    case (SI_SRC)
      `AWT_SI_FAST: si_tick = tick_fast;
      `AWT_SI_SLOW: si_tick = tick_slow;
      default: si_tick = e_si;
    endcase
  end
  assign si_req = st != awt_pkg::AWT_IDLE && si_tick && si_cnt == '0;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      si_cnt <= '0;
    end else if (st == awt_pkg::AWT_IDLE) begin
      si_cnt <= SI_RELOAD;
    end else if (si_tick) begin
      si_cnt <= si_cnt == '0 ? SI_RELOAD : si_cnt - CW'(1);
    end
  end

  // one scan holds exactly one conversion
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      scan_busy <= 1'b0;
      samp_cnt <= '0;
    end else if (scan_go) begin
      scan_busy <= 1'b1;
      samp_cnt <= SAMPLE_RELOAD;
    end else if (conv_go || st == awt_pkg::AWT_IDLE) begin
      scan_busy <= 1'b0;
      samp_cnt <= SAMPLE_RELOAD;
    end else if (scan_busy && samp_cnt != '0) begin
      samp_cnt <= samp_cnt - CW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generation
  logic [CW-1:0] ui_cnt, buf_cnt;
  logic wf_go, upd_go, upd_int;
  assign wf_go = e_wf && !WF_ACTIVE;
  assign upd_int = WF_ACTIVE && (UI_SLOW ? tick_slow : tick_fast) && ui_cnt == '0;
  assign upd_go = !AO_SW_GATE &&
                  (UPDATE_EXT ? (POSTED_UPDATE && e_ref) : upd_int);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      WF_ACTIVE <= 1'b0;
      ui_cnt <= '0;
      buf_cnt <= '0;
    end else if (wf_go) begin
      WF_ACTIVE <= 1'b1;
      ui_cnt <= UI_RELOAD;
      buf_cnt <= BUF_COUNT;
    end else if (AO_SW_STOP) begin
      WF_ACTIVE <= 1'b0;
    end else if (WF_ACTIVE) begin
      if (UI_SLOW ? tick_slow : tick_fast) begin
        ui_cnt <= ui_cnt == '0 ? UI_RELOAD : ui_cnt - CW'(1);
      end
      if (upd_go) begin
        buf_cnt <= buf_cnt - CW'(1);
        WF_ACTIVE <= buf_cnt > CW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pulse stretchers: start, post, convert, refresh, wave, scan
  logic [5:0] p_start, p_on;
  logic [2:0] p_cnt [6];
  assign p_start = {scan_go, wf_go, upd_go, conv_go, post_go, start_go};
  always_ff @(posedge CORE_CLK) begin
    for (int i = 0; i < 6; i++) begin
      if (RST) begin
        p_cnt[i] <= 3'h0;
      end else if (p_start[i]) begin
        p_cnt[i] <= (i == 2 || i == 3) ?
          3'(`AWT_CYC_UP(`AWT_CONV_PULSE_NS)) : 3'(`AWT_CYC_UP(`AWT_TRIG_PULSE_NS));
      end else if (p_cnt[i] != 3'h0) begin
        p_cnt[i] <= p_cnt[i] - 3'h1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      p_on[i] = p_cnt[i] != 3'h0;
    end
  end

  logic [`AWT_NUM_PINS-1:0] next_pin;
  always_comb begin
    next_pin = `AWT_PIN_IDLE;
    next_pin[`AWT_PIN_START] = p_on[0];
    next_pin[`AWT_PIN_POST] = p_on[1];
    next_pin[`AWT_PIN_CONV] = ~p_on[2];
    next_pin[`AWT_PIN_REFRESH] = ~p_on[3];
    next_pin[`AWT_PIN_WAVE] = p_on[4];
    next_pin[`AWT_PIN_SCAN] = SCAN_LEVEL_MODE ? scan_busy : p_on[5];
  end
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      PIN_OUT <= `AWT_PIN_IDLE;
      PIN_OE <= '0;
      ACQ_ACTIVE <= 1'b0;
      SCAN_BUSY <= 1'b0;
      ADC_CONVERT <= 1'b0;
      DAC_UPDATE <= 1'b0;
    end else begin
      PIN_OUT <= next_pin;
      PIN_OE <= PIN_DRIVE_EN;
      ACQ_ACTIVE <= st != awt_pkg::AWT_IDLE;
      SCAN_BUSY <= scan_busy;
      ADC_CONVERT <= conv_go;
      DAC_UPDATE <= upd_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mux advance strobe: delay then fixed width
  logic [6:0] mux_cnt;
  logic mux_act;
  assign mux_act = mux_cnt != 7'h0 && mux_cnt <= 7'(`AWT_CYC_DN(`AWT_MUX_WIDTH_NS));
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      mux_cnt <= 7'h0;
      MUX_ADVANCE <= 1'b0;
    end else begin
      if (conv_go) begin
        mux_cnt <= 7'(`AWT_CYC_UP(`AWT_MUX_DELAY_NS) + `AWT_CYC_DN(`AWT_MUX_WIDTH_NS));
      end else if (mux_cnt != 7'h0) begin
        mux_cnt <= mux_cnt - 7'h1;
      end
      MUX_ADVANCE <= MUX_EN ? (mux_act ^ MUX_POL) : 1'b0;
    end
  end

  // latch strobe: software level or burst of eight low pulses
  logic [4:0] stb_phase;
  logic [9:0] stb_cnt, stb_per;
  assign stb_per = STROBE_SLOW ? 10'(`AWT_CYC_DN(`AWT_STB_SLOW_NS) - 1) :
                                 10'(`AWT_CYC_DN(`AWT_STB_FAST_NS) - 1);
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      stb_phase <= 5'h0;
      stb_cnt <= 10'h0;
      LATCH_STROBE_N <= 1'b1;
    end else begin
      if (STROBE_HW_MODE && STROBE_GO && stb_phase == 5'h0) begin
        stb_phase <= 5'(`AWT_STB_PHASES);
        stb_cnt <= stb_per;
      end else if (stb_phase != 5'h0) begin
        stb_cnt <= stb_cnt == 10'h0 ? stb_per : stb_cnt - 10'h1;
        if (stb_cnt == 10'h0) begin
          stb_phase <= stb_phase - 5'h1;
        end
      end
      LATCH_STROBE_N <= STROBE_HW_MODE ?
        !(stb_phase != 5'h0 && !stb_phase[0]) : STROBE_SW_LEVEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence hi3_s(logic x);
    x [*3] ##1 !x;
  endsequence
  sequence lo5_s(logic x);
    !x [*5] ##1 x;
  endsequence
  post_pulse_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      $rose(PIN_OUT[`AWT_PIN_POST]) |-> hi3_s(PIN_OUT[`AWT_PIN_POST]))
    else $error("post trigger pulse width wrong");
  conv_pulse_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      $fell(PIN_OUT[`AWT_PIN_CONV]) |-> lo5_s(PIN_OUT[`AWT_PIN_CONV]))
    else $error("conversion pulse width wrong");
  refresh_pulse_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      $fell(PIN_OUT[`AWT_PIN_REFRESH]) |-> lo5_s(PIN_OUT[`AWT_PIN_REFRESH]))
    else $error("refresh pulse width wrong");
  pretrig_ignore_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      st == awt_pkg::AWT_PRE |=> st != awt_pkg::AWT_POST)
    else $error("post trigger taken during pretrigger count");
  scan_gate_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      scan_go |-> st != awt_pkg::AWT_IDLE && !gate_act ##1 scan_busy ##1 SCAN_BUSY)
    else $error("scan started outside sequence or while gated");
  one_conv_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      conv_go |-> scan_busy ##1 !scan_busy ##1 ADC_CONVERT == 1'b0)
    else $error("conversion not tied to one scan");
  mux_delay_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      ADC_CONVERT && MUX_EN && !MUX_POL && !MUX_ADVANCE &&
      mux_cnt > 7'(`AWT_CYC_DN(`AWT_MUX_WIDTH_NS))
      |-> ##6 $rose(MUX_ADVANCE))
    else $error("mux strobe delay wrong");
  upd_gate_a:
    assert property (@(posedge CORE_CLK) disable iff (RST)
      upd_go |-> !AO_SW_GATE ##1 DAC_UPDATE ##1 !PIN_OUT[`AWT_PIN_REFRESH])
    else $error("update while gated or refresh pin late");
endmodule
`default_nettype wire

//--- tb/awt_far_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "awt_defines.svh"
module awt_far_end (
  // clock
  input wire logic CORE_CLK,
  // pins toward the engine
  output logic [`AWT_NUM_PINS-1:0] PIN_IN
);
  initial PIN_IN = 10'h000;
  // held for whole cycles so the input synchronisers always see it
  task automatic pulse(input int idx, input int width);
    @(negedge CORE_CLK);
    PIN_IN[idx] = 1'b1;
    repeat (width) @(negedge CORE_CLK);
    PIN_IN[idx] = 1'b0;
  endtask
  task automatic level(input int idx, input logic val);
    @(negedge CORE_CLK);
    PIN_IN[idx] = val;
  endtask
endmodule
`default_nettype wire

//--- tb/acq_waveform_timing_engine_bench.sv
`timescale 1ns/10ps
`default_nettype none
module acq_waveform_timing_engine_bench;
  logic core_clk, rst;
  wire logic [9:0] pin_in;
  logic [9:0] pin_out, pin_oe, drive_en;
  logic [3:0] st_sel, pt_sel, ss_sel, cv_sel, g_sel, si_sel, wf_sel, rf_sel;
  logic st_pol, st_ext, sw_start, pt_pol, ss_pol, cv_pol, g_pol, si_pol, wf_pol, rf_pol;
  logic pre_mode, scan_ext, cv_ext, gate_en, sw_gate, sw_stop, lvl_mode;
  logic [15:0] pre_n, post_n, si_rl, smp_rl, ui_rl, buf_n;
  logic [1:0] si_src;
  logic mux_en, mux_pol, stb_hw, stb_lvl, stb_go, stb_slow;
  logic up_ext, ui_slow, posted, ao_gate, ao_stop;
  logic acq, busy, conv, wf, upd, mux, latch_n;
  int errors, total_checks, n_conv, n_upd, n_lat, cycles;
  int cnt [6];
  int w [6];

  awt_far_end i_far (.CORE_CLK(core_clk), .PIN_IN(pin_in));
  awt_engine #(.CW(16)) i_dut (
    .CORE_CLK(core_clk), .RST(rst), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_DRIVE_EN(drive_en), .START_TRIG_SEL(st_sel), .START_TRIG_POL(st_pol),
    .START_TRIG_EXT(st_ext), .SW_START(sw_start), .POST_TRIG_SEL(pt_sel),
    .POST_TRIG_POL(pt_pol), .SCAN_START_SEL(ss_sel), .SCAN_START_POL(ss_pol),
    .CONVERT_SEL(cv_sel), .CONVERT_POL(cv_pol), .GATE_SEL(g_sel), .GATE_POL(g_pol),
    .SI_CLK_SEL(si_sel), .SI_CLK_POL(si_pol), .WF_TRIG_SEL(wf_sel), .WF_TRIG_POL(wf_pol),
    .REFRESH_SEL(rf_sel), .REFRESH_POL(rf_pol), .PRETRIG_MODE(pre_mode),
    .PRETRIG_SCANS(pre_n), .POST_SCANS(post_n), .SCAN_EXT(scan_ext), .SI_SRC(si_src),
    .SI_RELOAD(si_rl), .CONVERT_EXT(cv_ext), .SAMPLE_RELOAD(smp_rl), .GATE_EN(gate_en),
    .SW_GATE(sw_gate), .SW_STOP(sw_stop), .SCAN_LEVEL_MODE(lvl_mode), .MUX_EN(mux_en),
    .MUX_POL(mux_pol), .STROBE_HW_MODE(stb_hw), .STROBE_SW_LEVEL(stb_lvl),
    .STROBE_GO(stb_go), .STROBE_SLOW(stb_slow), .UPDATE_EXT(up_ext), .UI_SLOW(ui_slow),
    .UI_RELOAD(ui_rl), .BUF_COUNT(buf_n), .POSTED_UPDATE(posted), .AO_SW_GATE(ao_gate),
    .AO_SW_STOP(ao_stop), .ACQ_ACTIVE(acq), .SCAN_BUSY(busy), .ADC_CONVERT(conv),
    .WF_ACTIVE(wf), .DAC_UPDATE(upd), .MUX_ADVANCE(mux), .LATCH_STROBE_N(latch_n));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("MISMATCH t=%0t run too long", $time);
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // counts pulses and the last completed width of the post, convert, refresh, wave, scan and mux pulses
  task automatic watch(input int lim);
    logic [5:0] act;
    logic prev;
    n_conv = 0;
    n_upd = 0;
    n_lat = 0;
    prev = latch_n;
    for (int i = 0; i < 6; i++) begin
      cnt[i] = 0;
      w[i] = 0;
    end
    repeat (lim) begin
      @(negedge core_clk);
      act = {mux, pin_out[7], pin_out[6], ~pin_out[5], ~pin_out[2], pin_out[1]};
      if (conv === 1'b1) n_conv++;
      if (upd === 1'b1) n_upd++;
      if (prev === 1'b1 && latch_n === 1'b0) n_lat++;
      prev = latch_n;
      for (int i = 0; i < 6; i++) begin
        if (act[i] === 1'b1) cnt[i]++;
        else if (cnt[i] > 0) begin
          w[i] = cnt[i];
          cnt[i] = 0;
        end
      end
    end
  endtask
  task automatic go_start();
    @(negedge core_clk);
    sw_start = 1'b1;
    @(negedge core_clk);
    sw_start = 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({6'h00, pin_out}, 16'h0024, "idle pins");
    chk({6'h00, pin_oe}, 16'h0000, "drivers off");
    chk(latch_n, 1'b1, "latch idle");
    drive_en = 10'h0e6;
    repeat (3) @(negedge core_clk);
    chk({6'h00, pin_oe}, 16'h00e6, "drivers on");
  endtask
  task automatic t_post();
    mux_en = 1'b1;
    go_start();
    watch(300);
    chk(n_conv, 16'd2, "post scans");
    chk(acq, 1'b0, "post halt");
    chk(w[1], 16'd5, "conv width");
    chk(w[4], 16'd3, "scan pulse");
    chk(w[5], 16'd45, "mux width");
    watch(200);
    chk(n_conv, 16'd0, "idle conv");
  endtask
  task automatic t_pretrig();
    pre_mode = 1'b1;
    go_start();
    i_far.pulse(1, 3);
    watch(400);
    chk(acq, 1'b1, "early post ignored");
    // post edge placed just after a conversion so no pretrigger scan is in flight
    do begin
      @(negedge core_clk);
    end while (conv !== 1'b1);
    i_far.pulse(1, 3);
    watch(300);
    chk(n_conv, 16'd2, "scans after post");
    chk(w[0], 16'd3, "post pulse");
    chk(acq, 1'b0, "pretrig halt");
    pre_mode = 1'b0;
  endtask
  task automatic t_gate();
    gate_en = 1'b1;
    i_far.level(3, 1'b1);
    repeat (5) @(negedge core_clk);
    go_start();
    watch(200);
    chk(n_conv, 16'd0, "gated scans");
    sw_stop = 1'b1;
    watch(5);
    chk(acq, 1'b0, "sw stop");
    sw_stop = 1'b0;
    gate_en = 1'b0;
    i_far.level(3, 1'b0);
  endtask
  task automatic t_ext();
    st_ext = 1'b1;
    scan_ext = 1'b1;
    ss_sel = 4'h4;
    cv_ext = 1'b1;
    cv_sel = 4'h3;
    lvl_mode = 1'b1;
    i_far.pulse(0, 3);
    fork
      repeat (2) begin
        i_far.pulse(4, 3);
        @(negedge core_clk);
        chk(busy, 1'b1, "scan busy");
        i_far.pulse(3, 3);
      end
      watch(60);
    join
    chk(n_conv, 16'd2, "external scans");
    chk(w[4], 16'd5, "scan level");
    chk(acq, 1'b0, "external halt");
    {st_ext, scan_ext, cv_ext, lvl_mode} = '0;
  endtask
  task automatic t_wave();
    i_far.pulse(8, 3);
    watch(400);
    chk(n_upd, 16'd4, "buffer updates");
    chk(wf, 1'b0, "buffer end");
    chk(w[3], 16'd3, "wave pulse");
    chk(w[2], 16'd5, "refresh width");
    ao_gate = 1'b1;
    i_far.pulse(8, 3);
    watch(300);
    chk(n_upd, 16'd0, "gated updates");
    ao_gate = 1'b0;
    up_ext = 1'b1;
    // watched alongside the pin pulse, the refresh edge gives no update strobe while posted mode is off
    fork
      i_far.pulse(9, 3);
      watch(50);
    join
    chk(n_upd, 16'd0, "no posted mode");
    posted = 1'b1;
    fork
      i_far.pulse(9, 3);
      watch(50);
    join
    chk(n_upd, 16'd1, "posted refresh");
    ao_stop = 1'b1;
    watch(5);
    chk(wf, 1'b0, "ao stop");
  endtask
  task automatic t_strobe();
    stb_lvl = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(latch_n, 1'b0, "sw level");
    stb_lvl = 1'b1;
    stb_hw = 1'b1;
    stb_go = 1'b1;
    @(negedge core_clk);
    stb_go = 1'b0;
    watch(2200);
    chk(n_lat, 16'd8, "burst count");
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {st_sel, ss_sel, cv_sel, st_pol, st_ext, sw_start, pt_pol, ss_pol, cv_pol} = '0;
    {g_pol, si_pol, wf_pol, rf_pol, pre_mode, scan_ext, cv_ext, gate_en} = '0;
    {sw_gate, sw_stop, lvl_mode, smp_rl, si_src, mux_en, mux_pol, stb_hw} = '0;
    {stb_go, stb_slow, up_ext, ui_slow, posted, ao_gate, ao_stop, drive_en} = '0;
    {errors, total_checks, cycles} = '0;
    pt_sel = 4'h1;
    g_sel = 4'h3;
    si_sel = 4'h4;
    wf_sel = 4'h8;
    rf_sel = 4'h9;
    pre_n = 16'h0003;
    post_n = 16'h0002;
    si_rl = 16'h0001;
    ui_rl = 16'h0001;
    buf_n = 16'h0004;
    stb_lvl = 1'b1;
    rst = 1'b1;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (5) @(negedge core_clk);
    t_reset();
    t_post();
    t_pretrig();
    t_gate();
    t_ext();
    t_wave();
    t_strobe();
    wrap_up();
  end
endmodule
`default_nettype wire
